// file: hw/csg_guard.v
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
// What this block does
// - Block interlock for addresses inside segment
// - General protection always still applies
// - Segment active only when disable bit 0
// - Boundary page is one inclusive 512-word page
// - End select 0: zero through boundary page
// - End select 1: boundary page through top
// - Bottom segment plus cfg bit 0: last page
// - Shadow complement kept, compared continuously
// - Unloaded bit change: parity error, reset
// - Config loaded from flash words, gcp guarded
// - Config words protectable by segment alone
// - Disabled segment adds no protection
`include "csg_map.vh"
module csg_guard #(
  parameter AW = 24,
  parameter MEM_TOP = 24'h0157ff
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire cfg_load_i,
  input wire [12:0] cfg_word_i,
  input wire req_valid_i,
  input wire [AW-1:0] req_addr_i,
  output wire req_allow_o,
  output wire req_block_o,
  output reg parity_err_o,
  output reg dev_reset_o,
  output wire irq_o
);
  reg [12:0] cfg_r;
  reg [12:0] shadow_r;
  reg [1:0] stat_r;
  reg [1:0] mask_r;
  reg [AW-1:0] last_r;
  reg rd_done_r;
  reg [3:0] rst_cnt_r;
  reg [1:0] stat_nxt;
  wire [7:0] page;
  wire seg_end;
  wire cfg_pg_n;
  wire seg_dis;
  wire gcp_n;
  wire general_write_protect_n;
  wire [AW-1:0] pg_base;
  wire [AW-1:0] pg_last;
  wire [AW-1:0] top_pg;
  wire in_bottom;
  wire in_top;
  wire in_cfgpg;
  wire seg_hit;
  wire gen_hit;
  wire [12:0] mismatch;
  wire par_evt;
  wire blk_evt;
  wire wr_ok;

  assign page = cfg_r[`CSG_CFG_PAGE_MSB:`CSG_CFG_PAGE_LSB];
  assign seg_end = cfg_r[`CSG_CFG_END_BIT];
  assign cfg_pg_n = cfg_r[`CSG_CFG_CPG_BIT];
  assign seg_dis = cfg_r[`CSG_CFG_DIS_BIT];
  assign gcp_n = cfg_r[`CSG_CFG_GCP_BIT];
  assign general_write_protect_n = cfg_r[`CSG_CFG_GENERAL_WRITE_PROTECT_BIT];

  assign pg_base = {{(AW-8){1'b0}}, page} << `CSG_PAGE_SHIFT;
  assign pg_last = pg_base | {{(AW-9){1'b0}}, 9'h1ff};
  assign top_pg = MEM_TOP & ~{{(AW-9){1'b0}}, 9'h1ff};
  assign in_bottom = (req_addr_i <= pg_last);
  assign in_top = (req_addr_i >= pg_base);
  assign in_cfgpg = (req_addr_i >= top_pg);
  // Config page independent of general bits
  assign seg_hit = !seg_dis && (seg_end ? in_top : (in_bottom || (!cfg_pg_n && in_cfgpg)));
  assign gen_hit = !gcp_n || !general_write_protect_n;
  assign req_block_o = req_valid_i && (seg_hit || gen_hit);
  assign req_allow_o = req_valid_i && !(seg_hit || gen_hit);

  assign mismatch = cfg_r ^ ~shadow_r;
  assign par_evt = |mismatch;
  assign blk_evt = req_block_o;

  assign wr_ok = avs_write_i;
  assign avs_waitrequest_o = avs_read_i && !rd_done_r;
  assign irq_o = |(stat_r & mask_r);

  always @* begin
    stat_nxt = stat_r;
    if (wr_ok && avs_address_i == `CSG_REG_STAT) begin
      stat_nxt = stat_r & ~avs_writedata_i[1:0];
    end
    if (blk_evt) begin
      stat_nxt[`CSG_ST_BLOCK] = 1'b1;
    end
    if (par_evt) begin
      stat_nxt[`CSG_ST_PARITY] = 1'b1;
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_r <= `CSG_CFG_RESET;
      shadow_r <= ~`CSG_CFG_RESET;
    end else if (cfg_load_i) begin
      cfg_r <= cfg_word_i;
      shadow_r <= ~cfg_word_i;
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      last_r <= {AW{1'b0}};
      rd_done_r <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_ok && avs_address_i == `CSG_REG_MASK) begin
        mask_r <= avs_writedata_i[1:0];
      end
      if (blk_evt) begin
        last_r <= req_addr_i;
      end
      rd_done_r <= avs_read_i && !rd_done_r;
      if (avs_read_i && !rd_done_r) begin
        case (avs_address_i)
          `CSG_REG_CFG: avs_readdata_o <= {19'h0, cfg_r};
          `CSG_REG_STAT: avs_readdata_o <= {30'h0, stat_r};
          `CSG_REG_MASK: avs_readdata_o <= {30'h0, mask_r};
          `CSG_REG_REQ: avs_readdata_o <= {30'h0, seg_hit, gen_hit};
          `CSG_REG_LAST: avs_readdata_o <= {{(32-AW){1'b0}}, last_r};
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      parity_err_o <= 1'b0;
      dev_reset_o <= 1'b0;
      rst_cnt_r <= 4'h0;
    end else begin
      parity_err_o <= par_evt;
      if (par_evt && rst_cnt_r == 4'h0) begin
        rst_cnt_r <= `CSG_RST_CYCLES;
        dev_reset_o <= 1'b1;
      end else if (rst_cnt_r != 4'h0) begin
        rst_cnt_r <= rst_cnt_r - 4'h1;
        dev_reset_o <= (rst_cnt_r != 4'h1);
      end
    end
  end
endmodule // csg_guard

// file: hw/csg_map.vh
`ifndef CSG_MAP_VH
`define CSG_MAP_VH
// Register word offsets
`define CSG_REG_CTRL 4'h0
`define CSG_REG_CFG 4'h1
`define CSG_REG_STAT 4'h2
`define CSG_REG_MASK 4'h3
`define CSG_REG_REQ 4'h4
`define CSG_REG_LAST 4'h5
// Config word field positions
`define CSG_CFG_PAGE_LSB 0
`define CSG_CFG_PAGE_MSB 7
`define CSG_CFG_END_BIT 8
`define CSG_CFG_CPG_BIT 9
`define CSG_CFG_DIS_BIT 10
`define CSG_CFG_GCP_BIT 11
`define CSG_CFG_GENERAL_WRITE_PROTECT_BIT 12
`define CSG_CFG_WIDTH 13
// Reset value: all unprogrammed
`define CSG_CFG_RESET 13'h1fff
// Status bit positions
`define CSG_ST_BLOCK 0
`define CSG_ST_PARITY 1
`define CSG_ST_WIDTH 2
// Page size as shift
`define CSG_PAGE_SHIFT 9
// Reset pulse cycles
`define CSG_RST_CYCLES 4'h8
`endif

// file: sim/csg_flash_ctl.sv
`timescale 1ns/10ps
module csg_flash_ctl (
  input wire core_clk_i,
  input wire block_i,
  input wire allow_i,
  output reg req_valid_o = 0,
  output reg [23:0] req_addr_o = 0,
  output reg cfg_load_o = 0,
  output reg [12:0] cfg_word_o = 0);
  task load(input [12:0] w); begin
    @(posedge core_clk_i); cfg_load_o <= 1; cfg_word_o <= w;
    @(posedge core_clk_i); cfg_load_o <= 0; cfg_word_o <= ~w;
  end endtask
  task req(input [23:0] a, output b, output w); begin
    @(posedge core_clk_i); req_valid_o <= 1; req_addr_o <= a;
    @(posedge core_clk_i); b = block_i; w = allow_i; req_valid_o <= 0; req_addr_o <= ~a;
  end endtask
endmodule // csg_flash_ctl

// file: sim/csg_guard_sva.sv
`timescale 1ns/10ps
module csg_guard_sva #(parameter AW = 24, parameter MEM_TOP = 24'h0157ff) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire cfg_load_i,
  input wire [12:0] cfg_word_i,
  input wire req_valid_i,
  input wire [AW-1:0] req_addr_i,
  input wire req_allow_o,
  input wire req_block_o,
  input wire parity_err_o);
  reg [12:0] c_r;
  wire on = req_valid_i && !c_r[10];
  always @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i) c_r <= 13'h1fff;
    else if (cfg_load_i) c_r <= cfg_word_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_one_verdict: assert property (req_valid_i |-> req_allow_o ^ req_block_o) else $error("x");
  a_gen_block: assert property (req_valid_i && !(&c_r[12:11]) |-> req_block_o) else $error("g");
  a_off_allow: assert property (req_valid_i && &c_r[12:10] |-> req_allow_o) else $error("d");
  a_top_seg: assert property (
    on && c_r[8] && req_addr_i[AW-1:9] >= c_r[7:0] |-> req_block_o) else $error("t");
  a_bot_seg: assert property (
    on && !c_r[8] && req_addr_i[AW-1:9] <= c_r[7:0] |-> req_block_o) else $error("b");
  a_cfg_page: assert property (
    on && c_r[9:8] == 2'h0 && req_addr_i[AW-1:9] >= (MEM_TOP >> 9) |-> req_block_o)
    else $error("c");
  a_below_allow: assert property (
    on && c_r[8] && &c_r[12:11] && req_addr_i[AW-1:9] < c_r[7:0] |-> req_allow_o)
    else $error("m");
  a_load_clean: assert property (cfg_load_i |-> ##3 !parity_err_o) else $error("p");
endmodule // csg_guard_sva
bind csg_guard csg_guard_sva #(.AW(AW), .MEM_TOP(MEM_TOP)) u_sva(.*);

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  reg clk = 0, rst_n = 0, rd = 0, wr = 0, b, w;
  wire alw, perr, drst;
  reg [3:0] ad = 0;
  reg [31:0] wd = 0;
  wire [31:0] q;
  wire wq, vld, ld, blk, irq;
  wire [23:0] ra;
  wire [12:0] cw;
  integer n_fail = 0, n_compared = 0, i;
  reg [12:0] tw [0:10] = '{13'h1fff, 13'h1b10, 13'h1b10, 13'h1b10, 13'h1a10, 13'h1a10,
    13'h1a10, 13'h1810, 13'h1c10, 13'h1410, 13'h0c10};
  reg [23:0] ta [0:10] = '{24'h0, 24'h1fff, 24'h2000, 24'h157ff, 24'h21ff, 24'h2200,
    24'h15600, 24'h15600, 24'h0, 24'h10000, 24'h100};
  reg [10:0] te = 11'h69c;
  always #10 clk = ~clk;
  csg_guard u_csg_guard(.core_clk_i(clk), .resetn_i(rst_n), .avs_address_i(ad),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(q),
    .avs_waitrequest_o(wq), .cfg_load_i(ld), .cfg_word_i(cw), .req_valid_i(vld),
    .req_addr_i(ra), .req_allow_o(alw), .req_block_o(blk), .parity_err_o(perr),
    .dev_reset_o(drst),
    .irq_o(irq));
  csg_flash_ctl u_csg_flash_ctl(.core_clk_i(clk), .block_i(blk), .allow_i(alw), .req_valid_o(vld),
    .req_addr_o(ra), .cfg_load_o(ld), .cfg_word_o(cw));
  task test_done; begin
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  task chk(input [31:0] g, input [31:0] e); begin
    n_compared++;
    if (g !== e) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end
  end endtask
  task acc(input w, input [3:0] a, input [31:0] v, input [31:0] e); integer k; begin
    @(posedge clk); rd <= !w; wr <= w; ad <= a; wd <= v;
    for (k = 0; k < 9; k++) begin @(posedge clk); if (!wq) break; end
    if (k == 9) begin n_fail++; test_done; end
    if (!w) chk(q, e);
    rd <= 0; wr <= 0;
  end endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    acc(0, 4'h1, 0, 32'h1fff);
    for (i = 0; i < 11; i++) begin
      u_csg_flash_ctl.load(tw[i]);
      u_csg_flash_ctl.req(ta[i], b, w);
      chk(b, te[i]);
      chk(w, !te[i]);
    end
    acc(0, 4'h5, 0, 32'h100);
    acc(0, 4'h2, 0, 32'h1);
    chk(irq, 0);
    acc(1, 4'h3, 32'h3, 0); @(posedge clk); chk(irq, 1);
    acc(1, 4'h2, 32'h1, 0); @(posedge clk); chk(irq, 0);
    acc(0, 4'h0, 0, 0);
    acc(0, 4'h7, 0, 0);
    acc(0, 4'h1, 0, 32'h0c10);
    acc(0, 4'h4, 0, 32'h1);
    chk({perr, drst}, 0);
    test_done;
  end
endmodule // testbench
